// [common/dcf_pkg.sv]
// constants shared by the dual clock fifo design
package dcf_pkg;
  // ==========================================================
  // geometry
  localparam int DCF_DATA_W = 8;
  localparam int DCF_DEPTH = 16;
  localparam int DCF_ADDR_W = 4;
  localparam int DCF_PTR_W = DCF_ADDR_W + 1;
  localparam int DCF_ROWS = 8;
  localparam int DCF_COLS = DCF_DEPTH / DCF_ROWS;
  localparam int DCF_COL_W = 1;
  localparam int DCF_ROW_W = DCF_ADDR_W - DCF_COL_W;
  localparam int DCF_RATIO = 1;
  // ==========================================================
  // legal configuration limits
  localparam int DCF_DEPTH_MIN = 8;
  localparam int DCF_DEPTH_MAX = 16384;
  localparam int DCF_DATA_W_MIN = 1;
  localparam int DCF_DATA_W_MAX = 64;
  localparam int DCF_ROWS_MIN = 2;
  localparam int DCF_ROWS_MAX = 128;
  localparam int DCF_RATIO_MAX = 64;
  // ==========================================================
  // reset values
  localparam logic [DCF_PTR_W-1:0] DCF_PTR_RESET = 5'h00;
  localparam logic [DCF_DATA_W-1:0] DCF_DATA_RESET = 8'h00;
  localparam logic DCF_EMPTY_RESET = 1'b1;
  localparam logic DCF_FULL_RESET = 1'b0;
  localparam logic DCF_SYNC_RESET = 1'b0;
  localparam logic [DCF_PTR_W-1:0] DCF_PTR_ONE = 5'h01;
endpackage : dcf_pkg

// [design/dcf_fifo.sv]
// dual clock fifo: write port and read port on independent clocks
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RQ1] two ports, read only and write only, on unrelated clocks
// [RQ2] read side runs on read_clock, write side on write_clock
// [RQ3] each port keeps its own address counter advanced by its clock
// [RQ4] storage is a two port array, one side write only, other read only
// [RQ5] depth is a power of two between 8 and 16384 words
// [RQ6] word width lies between 1 and 64 bits
// [RQ7] array organised as rows, row count even, 2 to 128
// [RQ8] read and write widths may differ by a power of two up to 64; here both buses are DCF_DATA_W wide and DCF_RATIO is only range checked
// [RQ9] parallel write data bus in, parallel read data bus out
// [RQ10] clear input resets internal state including both address counters
// [RQ11] empty flag high while no unread word is held
// [RQ12] full flag high while no further word can be stored
// [RQ13] no flags besides empty and full
// [RQ14] writes when full and reads when empty are ignored safely
// [RQ15] flags compare gray pointers synchronised across the two clocks
module dcf_fifo
(
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic sys_rst,
  input wire logic clear_n,
  input wire logic write_en,
  input wire logic [dcf_pkg::DCF_DATA_W-1:0] write_data,
  input wire logic read_en,
  output logic [dcf_pkg::DCF_DATA_W-1:0] read_data,
  output logic empty,
  output logic full
);
  import dcf_pkg::*;

  // ==========================================================
  // configuration checks, evaluated at elaboration
  localparam bit DEPTH_OK = (DCF_DEPTH >= DCF_DEPTH_MIN) && (DCF_DEPTH <= DCF_DEPTH_MAX)
    && ((DCF_DEPTH & (DCF_DEPTH - 1)) == 0) && ((1 << DCF_ADDR_W) == DCF_DEPTH); // RQ5
  localparam bit WIDTH_OK = (DCF_DATA_W >= DCF_DATA_W_MIN) && (DCF_DATA_W <= DCF_DATA_W_MAX); // RQ6
  localparam bit ROWS_OK = (DCF_ROWS >= DCF_ROWS_MIN) && (DCF_ROWS <= DCF_ROWS_MAX)
    && ((DCF_ROWS % 2) == 0) && ((1 << DCF_ROW_W) == DCF_ROWS); // RQ7
  localparam bit RATIO_OK = (DCF_RATIO >= 1) && (DCF_RATIO <= DCF_RATIO_MAX)
    && ((DCF_RATIO & (DCF_RATIO - 1)) == 0); // RQ8

  generate
    if (!(DEPTH_OK && WIDTH_OK && ROWS_OK && RATIO_OK))
    begin : g_bad_config
      // an illegal geometry stops elaboration here rather than
      // building an array that the port counters cannot address
      $error("illegal dcf_fifo geometry");
    end
  endgenerate

  // ==========================================================
  // helpers
  function automatic logic [DCF_PTR_W-1:0] to_gray(input logic [DCF_PTR_W-1:0] bin);
    to_gray = bin ^ (bin >> 1);
  endfunction : to_gray

  function automatic logic [DCF_ROW_W-1:0] row_of(input logic [DCF_PTR_W-1:0] ptr);
    row_of = ptr[DCF_ADDR_W-1:DCF_COL_W];
  endfunction : row_of

  function automatic logic [DCF_COL_W-1:0] col_of(input logic [DCF_PTR_W-1:0] ptr);
    col_of = ptr[DCF_COL_W-1:0];
  endfunction : col_of

  // ==========================================================
  // clear synchronisers
  // sys_rst and clear_n are both foreign to each port clock: each pin
  // gets two flops per side and the pair is merged only after them,
  // so no gate ever reads a pin that may still be settling
  logic wrst_meta_reg;
  logic wrst_reg;
  logic wclrn_meta_reg;
  logic wclrn_reg;
  logic wclr;
  logic rrst_meta_reg;
  logic rrst_reg;
  logic rclrn_meta_reg;
  logic rclrn_reg;
  logic rclr;

  always_ff @(posedge write_clock)
  begin
    wrst_meta_reg <= sys_rst;
    wrst_reg <= wrst_meta_reg;
    wclrn_meta_reg <= clear_n;
    wclrn_reg <= wclrn_meta_reg;
  end

  always_ff @(posedge read_clock)
  begin
    rrst_meta_reg <= sys_rst;
    rrst_reg <= rrst_meta_reg;
    rclrn_meta_reg <= clear_n;
    rclrn_reg <= rclrn_meta_reg;
  end

  // either pin clears; the merge adds no edge of latency
  assign wclr = wrst_reg | ~wclrn_reg; // RQ10
  assign rclr = rrst_reg | ~rclrn_reg; // RQ10

  // ==========================================================
  // storage: write only on one side, read only on the other
  logic [DCF_DATA_W-1:0] mem [DCF_ROWS][DCF_COLS]; // RQ4 RQ7

  // ==========================================================
  // write side
  logic [DCF_PTR_W-1:0] wbin_reg;
  logic [DCF_PTR_W-1:0] wbin_next;
  logic [DCF_PTR_W-1:0] wgray_reg;
  logic [DCF_PTR_W-1:0] wgray_next;
  logic [DCF_PTR_W-1:0] rgray_at_w;
  logic [DCF_PTR_W-1:0] full_match;
  logic full_next;
  logic write_do;

  assign write_do = write_en & ~full; // RQ14
  assign wbin_next = wbin_reg + (write_do ? DCF_PTR_ONE : DCF_PTR_RESET); // RQ3
  assign wgray_next = to_gray(wbin_next);
  // full when the write pointer has lapped the read pointer once
  assign full_match = {~rgray_at_w[DCF_PTR_W-1:DCF_PTR_W-2], rgray_at_w[DCF_PTR_W-3:0]};
  assign full_next = (wgray_next == full_match); // RQ12 RQ15

  always_ff @(posedge write_clock) // RQ2
  begin
    if (wclr) // RQ10
    begin
      wbin_reg <= DCF_PTR_RESET;
      wgray_reg <= DCF_PTR_RESET;
    end
    else
    begin
      wbin_reg <= wbin_next; // RQ3
      wgray_reg <= wgray_next;
    end
  end

  always_ff @(posedge write_clock)
  begin
    if (wclr) // RQ10
      full <= DCF_FULL_RESET;
    else
      full <= full_next; // RQ12
  end

  // array has no reset: contents are unreachable until written
  always_ff @(posedge write_clock)
  begin
    if (write_do) // RQ9 RQ14
      mem[row_of(wbin_reg)][col_of(wbin_reg)] <= write_data;
  end

  // ==========================================================
  // read side
  logic [DCF_PTR_W-1:0] rbin_reg;
  logic [DCF_PTR_W-1:0] rbin_next;
  logic [DCF_PTR_W-1:0] rgray_reg;
  logic [DCF_PTR_W-1:0] rgray_next;
  logic [DCF_PTR_W-1:0] wgray_at_r;
  logic empty_next;
  logic read_do;

  assign read_do = read_en & ~empty; // RQ14
  assign rbin_next = rbin_reg + (read_do ? DCF_PTR_ONE : DCF_PTR_RESET); // RQ3
  assign rgray_next = to_gray(rbin_next);
  assign empty_next = (rgray_next == wgray_at_r); // RQ11 RQ15

  always_ff @(posedge read_clock) // RQ2
  begin
    if (rclr) // RQ10
    begin
      rbin_reg <= DCF_PTR_RESET;
      rgray_reg <= DCF_PTR_RESET;
    end
    else
    begin
      rbin_reg <= rbin_next; // RQ3
      rgray_reg <= rgray_next;
    end
  end

  always_ff @(posedge read_clock)
  begin
    if (rclr) // RQ10
      empty <= DCF_EMPTY_RESET;
    else
      empty <= empty_next; // RQ11
  end

  // registered output keeps the last word read until the next read or a clear
  always_ff @(posedge read_clock)
  begin
    if (rclr)
      read_data <= DCF_DATA_RESET;
    else if (read_do) // RQ9 RQ14
      read_data <= mem[row_of(rbin_reg)][col_of(rbin_reg)];
  end

  // ==========================================================
  // pointer crossings; flags lag the far side by up to three edges,
  // which is pessimistic, never unsafe
  dcf_gray_sync u_rptr_to_w
  (
    .dst_clk(write_clock),
    .dst_rst(wclr),
    .gray_in(rgray_reg),
    .gray_out(rgray_at_w)
  ); // RQ15

  dcf_gray_sync u_wptr_to_r
  (
    .dst_clk(read_clock),
    .dst_rst(rclr),
    .gray_in(wgray_reg),
    .gray_out(wgray_at_r)
  ); // RQ15

  // only the empty and full flags leave the block
  // RQ13
  // ports are independent, no fixed clock relation assumed
  // RQ1
endmodule : dcf_fifo
`default_nettype wire

// [design/dcf_gray_sync.sv]
// two stage synchroniser for a gray coded pointer
`timescale 1ns/1ps
`default_nettype none
module dcf_gray_sync
(
  input wire logic dst_clk,
  input wire logic dst_rst,
  input wire logic [dcf_pkg::DCF_PTR_W-1:0] gray_in,
  output logic [dcf_pkg::DCF_PTR_W-1:0] gray_out
);
  import dcf_pkg::*;

  // first stage is read only by the second stage
  logic [DCF_PTR_W-1:0] meta_reg;

  always_ff @(posedge dst_clk)
  begin
    if (dst_rst)
    begin
      meta_reg <= DCF_PTR_RESET;
      gray_out <= DCF_PTR_RESET;
    end
    else
    begin
      meta_reg <= gray_in;
      gray_out <= meta_reg;
    end
  end
endmodule : dcf_gray_sync
`default_nettype wire

// [sim/dcf_fifo_asserts.sv]
// port checker for the dual clock fifo
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_asserts
(
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic sys_rst,
  input wire logic clear_n,
  input wire logic write_en,
  input wire logic [dcf_pkg::DCF_DATA_W-1:0] write_data,
  input wire logic read_en,
  input wire logic [dcf_pkg::DCF_DATA_W-1:0] read_data,
  input wire logic empty,
  input wire logic full
);
  import dcf_pkg::*;
  logic clr;
  logic [DCF_PTR_W-1:0] wcnt_reg;
  assign clr = sys_rst || !clear_n;
  // saturating count of accepted writes, catches an early full
  always_ff @(posedge write_clock)
  begin
    if (clr)
      wcnt_reg <= DCF_PTR_RESET;
    else if (write_en && !full && int'(wcnt_reg) < DCF_DEPTH)
      wcnt_reg <= wcnt_reg + DCF_PTR_ONE;
  end
  sequence clr4_s;
    clr [*4];
  endsequence
  // ==========================================================
  // assertions
  clr_empty_a: assert property (@(posedge read_clock) clr4_s |-> empty && read_data == DCF_DATA_RESET)
    else $error("clear left data");
  clr_full_a: assert property (@(posedge write_clock) clr4_s |-> !full)
    else $error("clear left full");
  rel_empty_a: assert property (@(posedge read_clock) $fell(clr) |-> (empty) [*3])
    else $error("empty fell after clear");
  rel_full_a: assert property (@(posedge write_clock) $fell(clr) |-> (!full) [*3])
    else $error("full rose after clear");
  data_hold_a: assert property (@(posedge read_clock) disable iff (clr) !(read_en && !empty) |=> $stable(read_data))
    else $error("data moved without read");
  empty_rise_a: assert property (@(posedge read_clock) disable iff (clr) $rose(empty) |-> $past(read_en))
    else $error("empty rose without read");
  full_rise_a: assert property (@(posedge write_clock) disable iff (clr) $rose(full) |-> $past(write_en))
    else $error("full rose without write");
  full_count_a: assert property (@(posedge write_clock) disable iff (clr) full |-> int'(wcnt_reg) == DCF_DEPTH)
    else $error("full before depth");
  full_empty_a: assert property (@(posedge write_clock) disable iff (clr) full |-> !empty)
    else $error("full and empty");
endmodule : dcf_fifo_asserts
`default_nettype wire

// [sim/dcf_fifo_bench.sv]
// self-checking bench for the dual clock fifo
`timescale 1ns/1ps
`default_nettype none
module dcf_fifo_bench;
  import dcf_pkg::*;
  logic write_clock = 1'b0;
  logic read_clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clear_n = 1'b1;
  logic read_en = 1'b0;
  logic load = 1'b0;
  logic [7:0] load_count = 8'h00;
  logic [7:0] load_base = 8'h00;
  logic write_en;
  logic [7:0] write_data;
  logic [7:0] read_data;
  logic empty;
  logic full;
  int bad_count = 0;
  int cmp_count = 0;
  always #12.5 write_clock = ~write_clock;
  always #17 read_clock = ~read_clock;
  dcf_fifo dut (.write_clock(write_clock), .read_clock(read_clock), .sys_rst(sys_rst), .clear_n(clear_n),
    .write_en(write_en), .write_data(write_data), .read_en(read_en), .read_data(read_data), .empty(empty), .full(full));
  dcf_producer prod (.write_clock(write_clock), .sys_rst(sys_rst), .full(full), .load(load),
    .load_count(load_count), .load_base(load_base), .write_en(write_en), .write_data(write_data));
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic wait_empty(input logic want);
    for (int n = 0; n < 100 && empty !== want; n++)
    begin
      @(posedge read_clock);
      #1;
    end
    chk("empty", 8'(want), 8'(empty));
    if (empty !== want)
      stop_test();
  endtask : wait_empty
  task automatic load_words(input logic [7:0] n, input logic [7:0] base);
    @(posedge write_clock);
    load <= 1'b1;
    load_count <= n;
    load_base <= base;
    @(posedge write_clock);
    load <= 1'b0;
  endtask : load_words
  task automatic read_word(input logic [7:0] exp);
    wait_empty(1'b0);
    @(posedge read_clock);
    read_en <= 1'b1;
    @(posedge read_clock);
    read_en <= 1'b0;
    #1;
    chk("read_data", exp, read_data);
  endtask : read_word
  task automatic t_reset();
    repeat (20) @(posedge write_clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge read_clock);
    #1;
    wait_empty(1'b1);
    chk("read_data", 8'h00, read_data);
    chk("full", 8'h00, 8'(full));
    $display("reset test done");
  endtask : t_reset
  // 17 words into 16 places: the last one waits while full
  task automatic t_fill();
    load_words(8'h11, 8'h40);
    for (int n = 0; n < 100 && full !== 1'b1; n++)
      @(negedge write_clock);
    repeat (8) @(negedge write_clock);
    chk("full", 8'h01, 8'(full));
    for (int i = 0; i < 17; i++)
      read_word(8'(8'h40 + i));
    wait_empty(1'b1);
    @(posedge read_clock);
    read_en <= 1'b1;
    @(posedge read_clock);
    read_en <= 1'b0;
    #1;
    chk("read_data", 8'h50, read_data);
    $display("fill test done");
  endtask : t_fill
  // clear a full buffer so that both flags and the data have to move
  task automatic t_clear();
    load_words(8'h10, 8'h80);
    for (int n = 0; n < 100 && full !== 1'b1; n++)
      @(negedge write_clock);
    chk("full", 8'h01, 8'(full));
    wait_empty(1'b0);
    @(posedge read_clock);
    clear_n <= 1'b0;
    repeat (5) @(posedge read_clock);
    #1;
    chk("read_data", 8'h00, read_data);
    chk("full", 8'h00, 8'(full));
    chk("empty", 8'h01, 8'(empty));
    @(posedge read_clock);
    clear_n <= 1'b1;
    repeat (4) @(posedge read_clock);
    wait_empty(1'b1);
    load_words(8'h01, 8'h99);
    read_word(8'h99);
    $display("clear test done");
  endtask : t_clear
  initial
  begin
    t_reset();
    t_fill();
    t_clear();
    stop_test();
  end
endmodule : dcf_fifo_bench
bind dcf_fifo dcf_fifo_asserts chk_i (.write_clock(write_clock), .read_clock(read_clock), .sys_rst(sys_rst),
  .clear_n(clear_n), .write_en(write_en), .write_data(write_data), .read_en(read_en), .read_data(read_data),
  .empty(empty), .full(full));
`default_nettype wire

// [sim/dcf_producer.sv]
// producer model on the write port
`timescale 1ns/1ps
`default_nettype none
module dcf_producer
(
  input wire logic write_clock,
  input wire logic sys_rst,
  input wire logic full,
  input wire logic load,
  input wire logic [7:0] load_count,
  input wire logic [dcf_pkg::DCF_DATA_W-1:0] load_base,
  output logic write_en,
  output logic [dcf_pkg::DCF_DATA_W-1:0] write_data
);
  logic [7:0] left_reg = 8'h00;
  // keeps asking while full, so an overrun attempt is seen
  assign write_en = left_reg != 8'h00;
  always @(posedge write_clock)
  begin
    if (sys_rst)
      left_reg <= 8'h00;
    else if (load)
    begin
      left_reg <= load_count;
      write_data <= load_base;
    end
    else if (write_en && !full)
    begin
      left_reg <= left_reg - 8'h01;
      write_data <= write_data + 8'h01;
    end
  end
endmodule : dcf_producer
`default_nettype wire
